// ### hdl/rrs_pkg.sv
// Constants and types shared by the reset release sequencer.
// Assumes a single 100 MHz system clock and a synchronous reset.
package rrs_pkg;

  // System clock period
  localparam int CLK_NS = 10;

  // Width of the delay counter
  localparam int CNT_W = 18;

  // Release times, typical figures, in ns
  localparam int FIRST_LVD_ON_NS = 672000;
  localparam int FIRST_LVD_OFF_NS = 399000;
  localparam int LATER_LVD_ON_NS = 531000;
  localparam int LATER_LVD_OFF_NS = 259000;

  // Voltage stabilization wait after power application, in ns
  localparam int STABILIZE_NS = 990000;

  // Same times as clock cycle counts
  localparam logic [CNT_W-1:0] FIRST_LVD_ON_CYC =
    CNT_W'((FIRST_LVD_ON_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] FIRST_LVD_OFF_CYC =
    CNT_W'((FIRST_LVD_OFF_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] LATER_LVD_ON_CYC =
    CNT_W'((LATER_LVD_ON_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] LATER_LVD_OFF_CYC =
    CNT_W'((LATER_LVD_OFF_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] STABILIZE_CYC =
    CNT_W'((STABILIZE_NS + CLK_NS - 1) / CLK_NS);

  // Counter value after reset
  localparam logic [CNT_W-1:0] CNT_RESET = 18'h00000;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_HOLD = 4'h1,
    ST_STABILIZE = 4'h2,
    ST_RELEASE = 4'h4,
    ST_RUN = 4'h8
  } rrs_state_e;

endpackage

// ### hdl/rrs_delay_counter.sv
// Down counter that times one wait and pulses when it expires.
// Assumes the loaded count is at least one cycle.
module rrs_delay_counter
  import rrs_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_load,
  input wire logic i_abort,
  input wire logic [rrs_pkg::CNT_W-1:0] i_count,
  output logic o_expired
);

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic busy_reg;
  logic busy_next;
  logic expired_reg;
  logic expired_next;

  always_comb
  begin
    count_next = count_reg;
    busy_next = busy_reg;
    expired_next = 1'b0;
    if (i_abort)
    begin
      busy_next = 1'b0;
      count_next = CNT_RESET;
    end
    else if (i_load)
    begin
      busy_next = 1'b1;
      count_next = i_count - 18'h00001;
    end
    else if (busy_reg)
    begin
      if (count_reg == CNT_RESET)
      begin
        busy_next = 1'b0;
        expired_next = 1'b1;
      end
      else
      begin
        count_next = count_reg - 18'h00001;
      end
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      count_reg <= CNT_RESET;
      busy_reg <= 1'b0;
      expired_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      busy_reg <= busy_next;
      expired_reg <= expired_next;
    end
  end

  assign o_expired = expired_reg;

endmodule

// ### hdl/rrs_sequencer.sv
// Reset release sequencer: holds the chip in reset and times its release.
// Assumes all inputs are synchronous to i_clk_sys; i_reset marks power-up.
module rrs_sequencer
  import rrs_pkg::*;
#(
  parameter logic [rrs_pkg::CNT_W-1:0] P_FIRST_LVD_ON_CYC = rrs_pkg::FIRST_LVD_ON_CYC,
  parameter logic [rrs_pkg::CNT_W-1:0] P_FIRST_LVD_OFF_CYC = rrs_pkg::FIRST_LVD_OFF_CYC,
  parameter logic [rrs_pkg::CNT_W-1:0] P_LATER_LVD_ON_CYC = rrs_pkg::LATER_LVD_ON_CYC,
  parameter logic [rrs_pkg::CNT_W-1:0] P_LATER_LVD_OFF_CYC = rrs_pkg::LATER_LVD_OFF_CYC,
  parameter logic [rrs_pkg::CNT_W-1:0] P_STABILIZE_CYC = rrs_pkg::STABILIZE_CYC
)
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_reset_pin_n,
  input wire logic i_por_detect,
  input wire logic i_lvd_detect,
  input wire logic i_wdt_overflow,
  input wire logic i_illegal_instr,
  input wire logic i_ram_parity_err,
  input wire logic i_illegal_access,
  input wire logic i_lvd_enable,
  input wire logic i_reset_out_latch,
  input wire logic i_reset_out_dir_out,
  output logic o_reset_active,
  output logic o_exec_start,
  output logic o_fast_osc_run,
  output logic o_cpu_clk_en,
  output logic o_main_xtal_stop,
  output logic o_main_xtal_pins_input,
  output logic o_sub_xtal_stop,
  output logic o_sub_xtal_pins_input,
  output logic o_ext_main_clk_ignore,
  output logic o_ext_sub_clk_ignore,
  output logic o_display_stop,
  output logic o_display_common_gnd,
  output logic o_display_segment_pin_hiz,
  output logic o_display_bias_hiz,
  output logic o_pump_cap_high_pin_hiz,
  output logic o_pump_cap_low_pin_hiz,
  output logic o_reset_out_port_pin_o,
  output logic o_reset_out_port_pin_oe,
  output logic o_pulled_up_debug_port_pin_pullup_en,
  output logic o_wdt_reset,
  output logic o_low_voltage_detector_reset
);

  // Sequencer state
  rrs_state_e state_reg;
  rrs_state_e state_next;
  logic power_new_reg;
  logic power_new_next;
  logic released_once_reg;
  logic released_once_next;
  logic src_pin_por_reg;
  logic src_pin_por_next;
  logic src_lvd_reg;
  logic src_lvd_next;

  // Delay counter control
  logic cnt_load;
  logic cnt_abort;
  logic [CNT_W-1:0] cnt_value;
  logic cnt_expired;

  // Output registers
  logic reset_active_reg;
  logic exec_start_reg;
  logic exec_start_next;
  logic debug_pullup_reg;
  logic debug_pullup_next;
  logic wdt_reset_reg;
  logic lvd_reset_reg;
  logic lvd_reset_next;
  logic reset_out_o_reg;
  logic reset_out_o_next;
  logic reset_out_oe_reg;
  logic reset_out_oe_next;
  logic run_reg;
  logic run_next;
  logic main_xtal_hold_reg;
  logic main_xtal_hold_next;
  logic sub_xtal_hold_reg;
  logic sub_xtal_hold_next;
  logic ext_clk_hold_reg;
  logic ext_clk_hold_next;
  logic display_gnd_reg;
  logic display_gnd_next;
  logic display_hiz_reg;
  logic display_hiz_next;

  // Request decode
  logic pin_or_por;
  logic internal_req;
  logic in_reset_next;
  logic [CNT_W-1:0] release_cyc;

  assign pin_or_por = !i_reset_pin_n || i_por_detect;
  assign internal_req = i_lvd_detect || i_wdt_overflow || i_illegal_instr
                        || i_ram_parity_err || i_illegal_access;

  // Release delay selection
  always_comb
  begin
    if (!released_once_reg)
    begin
      if (i_lvd_enable)
      begin
        release_cyc = P_FIRST_LVD_ON_CYC;
      end
      else
      begin
        release_cyc = P_FIRST_LVD_OFF_CYC;
      end
    end
    else
    begin
      if (i_lvd_enable)
      begin
        release_cyc = P_LATER_LVD_ON_CYC;
      end
      else
      begin
        release_cyc = P_LATER_LVD_OFF_CYC;
      end
    end
  end

  // Sequencer next state
  always_comb
  begin
    state_next = state_reg;
    power_new_next = power_new_reg;
    released_once_next = released_once_reg;
    src_pin_por_next = src_pin_por_reg;
    src_lvd_next = src_lvd_reg;
    cnt_load = 1'b0;
    cnt_abort = 1'b0;
    cnt_value = release_cyc;
    if (pin_or_por)
    begin
      state_next = ST_HOLD;
      cnt_abort = 1'b1;
      src_pin_por_next = 1'b1;
      src_lvd_next = 1'b0;
      if (i_por_detect)
      begin
        power_new_next = 1'b1;
        released_once_next = 1'b0;
      end
    end
    else
    begin
      unique case (state_reg)
        ST_HOLD:
        begin
          if (internal_req)
          begin
            src_lvd_next = src_lvd_reg || i_lvd_detect;
          end
          else if (power_new_reg)
          begin
            state_next = ST_STABILIZE;
            cnt_load = 1'b1;
            cnt_value = P_STABILIZE_CYC;
          end
          else
          begin
            state_next = ST_RELEASE;
            cnt_load = 1'b1;
          end
        end
        ST_STABILIZE:
        begin
          if (cnt_expired)
          begin
            power_new_next = 1'b0;
            state_next = ST_RELEASE;
            cnt_load = 1'b1;
          end
        end
        ST_RELEASE:
        begin
          if (internal_req)
          begin
            state_next = ST_HOLD;
            cnt_abort = 1'b1;
            src_lvd_next = src_lvd_reg || i_lvd_detect;
          end
          else if (cnt_expired)
          begin
            state_next = ST_RUN;
            released_once_next = 1'b1;
          end
        end
        ST_RUN:
        begin
          if (internal_req)
          begin
            state_next = ST_HOLD;
            src_pin_por_next = 1'b0;
            src_lvd_next = i_lvd_detect;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      state_reg <= ST_HOLD;
      power_new_reg <= 1'b1;
      released_once_reg <= 1'b0;
      src_pin_por_reg <= 1'b1;
      src_lvd_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      power_new_reg <= power_new_next;
      released_once_reg <= released_once_next;
      src_pin_por_reg <= src_pin_por_next;
      src_lvd_reg <= src_lvd_next;
    end
  end

  rrs_delay_counter u_delay
  (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_load(cnt_load),
    .i_abort(cnt_abort),
    .i_count(cnt_value),
    .o_expired(cnt_expired)
  );

  // Output next values
  always_comb
  begin
    in_reset_next = (state_next != ST_RUN);
    exec_start_next = (state_reg == ST_RELEASE) && (state_next == ST_RUN);
    debug_pullup_next = !(in_reset_next && src_pin_por_next);
    lvd_reset_next = in_reset_next && !src_lvd_next;
    run_next = !in_reset_next;
    main_xtal_hold_next = in_reset_next;
    sub_xtal_hold_next = in_reset_next;
    ext_clk_hold_next = in_reset_next;
    display_gnd_next = in_reset_next;
    display_hiz_next = in_reset_next;
    if (in_reset_next)
    begin
      reset_out_o_next = 1'b0;
      reset_out_oe_next = 1'b1;
    end
    else
    begin
      reset_out_o_next = i_reset_out_latch;
      reset_out_oe_next = i_reset_out_dir_out;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      reset_active_reg <= 1'b1;
      exec_start_reg <= 1'b0;
      debug_pullup_reg <= 1'b0;
      wdt_reset_reg <= 1'b1;
      lvd_reset_reg <= 1'b1;
      reset_out_o_reg <= 1'b0;
      reset_out_oe_reg <= 1'b1;
      run_reg <= 1'b0;
      main_xtal_hold_reg <= 1'b1;
      sub_xtal_hold_reg <= 1'b1;
      ext_clk_hold_reg <= 1'b1;
      display_gnd_reg <= 1'b1;
      display_hiz_reg <= 1'b1;
    end
    else
    begin
      reset_active_reg <= in_reset_next;
      exec_start_reg <= exec_start_next;
      debug_pullup_reg <= debug_pullup_next;
      wdt_reset_reg <= in_reset_next;
      lvd_reset_reg <= lvd_reset_next;
      reset_out_o_reg <= reset_out_o_next;
      reset_out_oe_reg <= reset_out_oe_next;
      run_reg <= run_next;
      main_xtal_hold_reg <= main_xtal_hold_next;
      sub_xtal_hold_reg <= sub_xtal_hold_next;
      ext_clk_hold_reg <= ext_clk_hold_next;
      display_gnd_reg <= display_gnd_next;
      display_hiz_reg <= display_hiz_next;
    end
  end

  // Every output is driven straight from a flop, so no output passes through logic
  assign o_reset_active = reset_active_reg;
  assign o_exec_start = exec_start_reg;
  assign o_fast_osc_run = run_reg;
  assign o_cpu_clk_en = run_reg;
  assign o_main_xtal_stop = main_xtal_hold_reg;
  assign o_main_xtal_pins_input = main_xtal_hold_reg;
  assign o_sub_xtal_stop = sub_xtal_hold_reg;
  assign o_sub_xtal_pins_input = sub_xtal_hold_reg;
  assign o_ext_main_clk_ignore = ext_clk_hold_reg;
  assign o_ext_sub_clk_ignore = ext_clk_hold_reg;
  assign o_display_stop = display_gnd_reg;
  assign o_display_common_gnd = display_gnd_reg;
  assign o_display_segment_pin_hiz = display_hiz_reg;
  assign o_display_bias_hiz = display_hiz_reg;
  assign o_pump_cap_high_pin_hiz = display_hiz_reg;
  assign o_pump_cap_low_pin_hiz = display_hiz_reg;
  assign o_reset_out_port_pin_o = reset_out_o_reg;
  assign o_reset_out_port_pin_oe = reset_out_oe_reg;
  assign o_pulled_up_debug_port_pin_pullup_en = debug_pullup_reg;
  assign o_wdt_reset = wdt_reset_reg;
  assign o_low_voltage_detector_reset = lvd_reset_reg;

endmodule

// ### testbench/rrs_seq_asserts.sv
// Port checker for the reset release sequencer.
// Bound to rrs_sequencer; one clock domain, synchronous reset.
module rrs_seq_asserts
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_reset_pin_n,
  input wire logic i_por_detect,
  input wire logic i_lvd_detect,
  input wire logic i_reset_out_latch,
  input wire logic i_reset_out_dir_out,
  input wire logic o_reset_active,
  input wire logic o_exec_start,
  input wire logic o_fast_osc_run,
  input wire logic o_cpu_clk_en,
  input wire logic o_main_xtal_stop,
  input wire logic o_main_xtal_pins_input,
  input wire logic o_sub_xtal_stop,
  input wire logic o_sub_xtal_pins_input,
  input wire logic o_ext_main_clk_ignore,
  input wire logic o_ext_sub_clk_ignore,
  input wire logic o_display_stop,
  input wire logic o_display_common_gnd,
  input wire logic o_display_segment_pin_hiz,
  input wire logic o_display_bias_hiz,
  input wire logic o_pump_cap_high_pin_hiz,
  input wire logic o_pump_cap_low_pin_hiz,
  input wire logic o_reset_out_port_pin_o,
  input wire logic o_reset_out_port_pin_oe,
  input wire logic o_pulled_up_debug_port_pin_pullup_en,
  input wire logic o_wdt_reset,
  input wire logic o_low_voltage_detector_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  sequence start_seq;
    o_exec_start && o_fast_osc_run ##1 !o_exec_start;
  endsequence
  pin_entry_a: assert property (!i_reset_pin_n |=> o_reset_active)
    else $error("pin low without reset");
  exec_start_a: assert property ($fell(o_reset_active) |-> start_seq)
    else $error("no start pulse on release");
  exec_only_a: assert property (o_exec_start |-> $fell(o_reset_active))
    else $error("start pulse without release");
  osc_run_a: assert property (o_fast_osc_run == !o_reset_active)
    else $error("fast oscillator state wrong");
  cpu_clk_a: assert property (o_cpu_clk_en == !o_reset_active)
    else $error("cpu clock during reset");
  xtal_stop_a: assert property ({o_main_xtal_stop, o_main_xtal_pins_input,
    o_sub_xtal_stop, o_sub_xtal_pins_input} == {4{o_reset_active}})
    else $error("oscillator runs in reset");
  ext_clk_a: assert property ({o_ext_main_clk_ignore, o_ext_sub_clk_ignore}
    == {2{o_reset_active}})
    else $error("clock input not ignored");
  display_a: assert property ({o_display_stop, o_display_common_gnd,
    o_display_segment_pin_hiz, o_display_bias_hiz, o_pump_cap_high_pin_hiz,
    o_pump_cap_low_pin_hiz} == {6{o_reset_active}})
    else $error("display pins wrong in reset");
  resout_low_a: assert property (o_reset_active |->
    !o_reset_out_port_pin_o && o_reset_out_port_pin_oe)
    else $error("reset output not low");
  resout_follow_a: assert property (!o_reset_active |->
    o_reset_out_port_pin_o == $past(i_reset_out_latch)
    && o_reset_out_port_pin_oe == $past(i_reset_out_dir_out))
    else $error("reset output not following latch");
  debug_float_a: assert property (!i_reset_pin_n || i_por_detect |=>
    !o_pulled_up_debug_port_pin_pullup_en)
    else $error("debug pin pulled in pin reset");
  debug_pull_a: assert property (!o_reset_active |-> o_pulled_up_debug_port_pin_pullup_en)
    else $error("debug pin not pulled after reset");
  wdt_reset_a: assert property (o_wdt_reset == o_reset_active)
    else $error("watchdog not reset");
  lvd_keep_a: assert property (i_lvd_detect && i_reset_pin_n && !i_por_detect
    && !o_reset_active |=> o_reset_active && !o_low_voltage_detector_reset)
    else $error("detector reset by own request");
endmodule
bind rrs_sequencer rrs_seq_asserts i_chk
(
  .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_reset_pin_n(i_reset_pin_n),
  .i_por_detect(i_por_detect), .i_lvd_detect(i_lvd_detect),
  .i_reset_out_latch(i_reset_out_latch), .i_reset_out_dir_out(i_reset_out_dir_out),
  .o_reset_active(o_reset_active), .o_exec_start(o_exec_start),
  .o_fast_osc_run(o_fast_osc_run), .o_cpu_clk_en(o_cpu_clk_en),
  .o_main_xtal_stop(o_main_xtal_stop), .o_main_xtal_pins_input(o_main_xtal_pins_input),
  .o_sub_xtal_stop(o_sub_xtal_stop), .o_sub_xtal_pins_input(o_sub_xtal_pins_input),
  .o_ext_main_clk_ignore(o_ext_main_clk_ignore), .o_ext_sub_clk_ignore(o_ext_sub_clk_ignore),
  .o_display_stop(o_display_stop), .o_display_common_gnd(o_display_common_gnd),
  .o_display_segment_pin_hiz(o_display_segment_pin_hiz), .o_display_bias_hiz(o_display_bias_hiz),
  .o_pump_cap_high_pin_hiz(o_pump_cap_high_pin_hiz),
  .o_pump_cap_low_pin_hiz(o_pump_cap_low_pin_hiz),
  .o_reset_out_port_pin_o(o_reset_out_port_pin_o),
  .o_reset_out_port_pin_oe(o_reset_out_port_pin_oe),
  .o_pulled_up_debug_port_pin_pullup_en(o_pulled_up_debug_port_pin_pullup_en),
  .o_wdt_reset(o_wdt_reset), .o_low_voltage_detector_reset(o_low_voltage_detector_reset)
);

// ### testbench/rrs_ext_party.sv
// Far side: external reset source and a device held by the reset output.
// An undriven reset output floats; the device sees a toggling level then.
module rrs_ext_party
(
  input wire logic i_clk_sys,
  input wire logic i_hold,
  input wire logic i_pin_o,
  input wire logic i_pin_oe,
  output logic o_reset_pin_n,
  output logic o_dev_in_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  logic float_reg = 1'b0;
  always_ff @(posedge i_clk_sys) float_reg <= !float_reg;
  assign o_reset_pin_n = !i_hold;
  assign o_dev_in_reset = i_pin_oe ? !i_pin_o : float_reg;
endmodule

// ### testbench/tb.sv
// Self-checking bench for the reset release sequencer with short delays.
// Assumes the external party model and the bound port checker.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rrs_pkg::*;
  localparam int F_ON = 20, F_OFF = 12, L_ON = 16, L_OFF = 8, STAB = 30;
  typedef struct {logic [6:0] c; logic en; int n;} rrs_row_s;
  rrs_row_s rows [9] = '{'{7'h02, 1'b1, STAB + F_ON + 3}, '{7'h01, 1'b0, L_OFF + 2},
    '{7'h01, 1'b1, L_ON + 2}, '{7'h02, 1'b0, STAB + F_OFF + 3}, '{7'h08, 1'b0, L_OFF + 2},
    '{7'h10, 1'b1, L_ON + 2}, '{7'h20, 1'b0, L_OFF + 2}, '{7'h40, 1'b0, L_OFF + 2},
    '{7'h04, 1'b1, L_ON + 2}};
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [6:0] cause_v = 7'h00;
  logic lvd_en = 1'b1;
  logic latch = 1'b1;
  logic dir = 1'b1;
  logic pin_n, reset_active, exec_start, fast_osc, rout_o, rout_oe;
  logic pullup_en, wdt_rst, lvd_rst, dev_in_reset;
  int errors = 0;
  int n_checks = 0;
  int n;
  initial forever #5 clk_sys = !clk_sys;
  rrs_ext_party i_party (.i_clk_sys(clk_sys), .i_hold(cause_v[0]), .i_pin_o(rout_o),
    .i_pin_oe(rout_oe), .o_reset_pin_n(pin_n), .o_dev_in_reset(dev_in_reset));
  rrs_sequencer #(.P_FIRST_LVD_ON_CYC(18'(F_ON)), .P_FIRST_LVD_OFF_CYC(18'(F_OFF)),
    .P_LATER_LVD_ON_CYC(18'(L_ON)), .P_LATER_LVD_OFF_CYC(18'(L_OFF)),
    .P_STABILIZE_CYC(18'(STAB))) i_dut (
    .i_clk_sys(clk_sys), .i_reset(reset), .i_reset_pin_n(pin_n), .i_por_detect(cause_v[1]),
    .i_lvd_detect(cause_v[2]), .i_wdt_overflow(cause_v[3]), .i_illegal_instr(cause_v[4]),
    .i_ram_parity_err(cause_v[5]), .i_illegal_access(cause_v[6]), .i_lvd_enable(lvd_en),
    .i_reset_out_latch(latch), .i_reset_out_dir_out(dir), .o_reset_active(reset_active),
    .o_exec_start(exec_start), .o_fast_osc_run(fast_osc), .o_cpu_clk_en(),
    .o_main_xtal_stop(), .o_main_xtal_pins_input(), .o_sub_xtal_stop(),
    .o_sub_xtal_pins_input(), .o_ext_main_clk_ignore(), .o_ext_sub_clk_ignore(),
    .o_display_stop(), .o_display_common_gnd(), .o_display_segment_pin_hiz(),
    .o_display_bias_hiz(), .o_pump_cap_high_pin_hiz(), .o_pump_cap_low_pin_hiz(),
    .o_reset_out_port_pin_o(rout_o), .o_reset_out_port_pin_oe(rout_oe),
    .o_pulled_up_debug_port_pin_pullup_en(pullup_en), .o_wdt_reset(wdt_rst),
    .o_low_voltage_detector_reset(lvd_rst));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s exp %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Counts cycles from release of the cause until reset ends
  task automatic wait_release(output int cnt);
    cnt = 0;
    do
    begin
      @(posedge clk_sys);
      #1 cnt++;
    end
    while (reset_active === 1'b1 && cnt < 500);
  endtask

  // Applies a cause for three cycles, checks reset state, releases it
  task automatic fire(input logic [6:0] c, output int cnt);
    cause_v = c;
    repeat (3) @(posedge clk_sys);
    #1 check("active", reset_active, 1'b1);
    check("dev_held", dev_in_reset, 1'b1);
    check("pullup", pullup_en, !(c[0] | c[1]));
    check("lvd_rst", lvd_rst, !c[2]);
    check("wdt_rst", wdt_rst, 1'b1);
    cause_v = 7'h00;
    wait_release(cnt);
  endtask

  initial
  begin
    #100us;
    errors++;
    wrap_up();
  end

  initial
  begin
    repeat (12) @(posedge clk_sys);
    #1 check("cold_pullup", pullup_en, 1'b0);
    reset = 1'b0;
    wait_release(n);
    check("cold_cycles", n, STAB + F_ON + 3);
    check("cold_start", exec_start, 1'b1);
    $display("test cold done");
    foreach (rows[i])
    begin
      lvd_en = rows[i].en;
      fire(rows[i].c, n);
      check("cycles", n, rows[i].n);
      check("exec", exec_start, 1'b1);
      check("osc", fast_osc, 1'b1);
      check("pullup_after", pullup_en, 1'b1);
      @(posedge clk_sys);
      #1 check("dev_freed", dev_in_reset, 1'b0);
      $display("test row %0d done", i);
    end
    lvd_en = 1'b0;
    cause_v = 7'h01;
    repeat (3) @(posedge clk_sys);
    #1 cause_v = 7'h00;
    repeat (4) @(posedge clk_sys);
    #1 fire(7'h01, n);
    check("abort_cycles", n, L_OFF + 2);
    $display("test abort done");
    fire(7'h08, n);
    fire(7'h10, n);
    check("back_to_back", n, L_OFF + 2);
    $display("test back to back done");
    latch = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 check("dev_relatch", dev_in_reset, 1'b1);
    latch = 1'b1;
    $display("test latch follow done");
    reset = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 check("warm_active", reset_active, 1'b1);
    check("warm_pullup", pullup_en, 1'b0);
    reset = 1'b0;
    wait_release(n);
    check("warm_cycles", n, STAB + F_OFF + 3);
    check("warm_start", exec_start, 1'b1);
    $display("test warm reset done");
    wrap_up();
  end
endmodule
